/* File: fpg_port.sv */
/*
 * Fan pin general I/O: setup and state registers, pin drive and input
 * sampling for four repurposed fan-drive pins.
 * Assumes the serial host decoder issues one-cycle read and write
 * strobes on ref_clk, and the fan controller supplies its drive levels.
 */
`timescale 1ns/10ps
module fpg_port
    import fpg_pkg::*;
#(
    parameter int PINS = FPG_PINS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire fpg_req_t req,
    output logic [7:0] rd_data,
    input wire logic [3:0] repurpose_enable,
    input wire logic [3:0] min_duty_lsb,
    input wire logic [3:0] fan_drive_level,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n
);
    // Refuse widths that the fixed four-pin register layout cannot serve.
    if (PINS != FPG_PINS) begin : g_pins_check
        $error("fpg_port serves exactly four pins");
    end

    function automatic int dir_pos(input int i);
        return FPG_DIR_POS1 - FPG_FIELD_STEP * i;
    endfunction

    function automatic int pol_pos(input int i);
        return FPG_POL_POS1 - FPG_FIELD_STEP * i;
    endfunction

    logic [7:0] setup_q, setup_d;
    logic [7:0] state_q, state_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic [3:0] pin_out_q, pin_out_d;
    logic [3:0] pin_oe_n_q, pin_oe_n_d;
    logic [3:0] s1_q, s2_q, s3_q, filt_q;
    logic [3:0] filt_d;
    logic [3:0] en, dir, pol, asserted_in;

    // Per-pin views of the enable, direction and polarity fields.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            en[i] = repurpose_enable[FPG_EN_POS1 - i];
            dir[i] = setup_q[dir_pos(i)];
            pol[i] = setup_q[pol_pos(i)];
            asserted_in[i] = pol[i] ? filt_q[i] : ~filt_q[i];
        end
    end

    // Three-stage sampler; a change counts once stages two and three agree.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
            filt_q <= 4'h0;
        end else if (ce) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    // Register writes, live input state, read data and pin drive.
    always_comb begin
        logic wr_setup, wr_state;
        logic on;
        on = 1'b0;
        wr_setup = req.wr && (req.addr == FPG_SETUP_ADDR);
        wr_state = req.wr && (req.addr == FPG_STATE_ADDR);
        setup_d = wr_setup ? req.wdata : setup_q;
        state_d = state_q;
        if (wr_state) begin
            state_d[FPG_TEST_MSB:0] = req.wdata[FPG_TEST_MSB:0];
        end
        pin_out_d = 4'h0;
        pin_oe_n_d = 4'hf;
        for (int i = 0; i < 4; i++) begin
            if (en[i] && !dir[i]) begin
                // Input pins: bit follows the sampled asserted level.
                state_d[FPG_STATE_POS1 + i] = asserted_in[i];
            end else if (wr_state) begin
                state_d[FPG_STATE_POS1 + i] =
                    req.wdata[FPG_STATE_POS1 + i];
            end
            if (en[i]) begin
                // Asserted when the state bit or duty LSB asks for it.
                on = state_q[FPG_STATE_POS1 + i] | min_duty_lsb[i];
                pin_out_d[i] = pol[i] ? on : ~on;
                pin_oe_n_d[i] = ~dir[i];
            end else begin
                pin_out_d[i] = fan_drive_level[i];
                pin_oe_n_d[i] = 1'b0;
            end
        end
        rd_data_d = rd_data_q;
        if (req.rd) begin
            case (req.addr)
                FPG_SETUP_ADDR: rd_data_d = setup_q;
                FPG_STATE_ADDR: rd_data_d = state_q;
                default: rd_data_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            setup_q <= FPG_SETUP_RST;
            state_q <= FPG_STATE_RST;
            rd_data_q <= 8'h00;
            pin_out_q <= 4'h0;
            pin_oe_n_q <= 4'hf;
        end else if (ce) begin
            setup_q <= setup_d;
            state_q <= state_d;
            rd_data_q <= rd_data_d;
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    assign rd_data = rd_data_q;
    assign pin_out = pin_out_q;
    assign pin_oe_n = pin_oe_n_q;

    // Checks on register and pin behaviour.
    // A setup write lands in the register one edge later.
    setup_write_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && req.wr && req.addr == FPG_SETUP_ADDR
        |=> setup_q == $past(req.wdata))
        else $error("setup write lost");
    // An enabled output pin is driven on the next edge.
    out_dir_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && repurpose_enable[FPG_EN_POS1] && setup_q[FPG_DIR_POS1]
        |=> !pin_oe_n[0])
        else $error("pin 1 output not driven");
    // An enabled input pin is released on the next edge.
    in_dir_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && repurpose_enable[FPG_EN_POS1] && !setup_q[FPG_DIR_POS1]
        |=> pin_oe_n[0])
        else $error("pin 1 input driven");
    // Output level follows state or duty data through the polarity.
    pol_drive_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && repurpose_enable[FPG_EN_POS1 - 1]
        && setup_q[dir_pos(1)]
        |=> pin_out[1] == ($past(setup_q[pol_pos(1)])
            ~^ ($past(state_q[FPG_STATE_POS1 + 1])
            | $past(min_duty_lsb[1]))))
        else $error("pin 2 output level wrong");
    // Duty data alone asserts an active-high output pin.
    duty_out_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && repurpose_enable[0] && setup_q[dir_pos(3)]
        && setup_q[pol_pos(3)] && min_duty_lsb[3]
        |=> pin_out[3] && !pin_oe_n[3])
        else $error("pin 4 duty data not driven");
    // Input state bit shows the asserted level in the top nibble.
    in_state_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && repurpose_enable[0] && !setup_q[dir_pos(3)]
        |=> state_q[FPG_STATE_POS1 + 3]
            == ($past(setup_q[pol_pos(3)]) ~^ $past(filt_q[3])))
        else $error("pin 4 input state wrong");
    // Writes cannot override the state bit of an input pin.
    in_ro_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && repurpose_enable[FPG_EN_POS1] && !setup_q[FPG_DIR_POS1]
        && req.wr && req.addr == FPG_STATE_ADDR
        |=> state_q[FPG_STATE_POS1] == $past(asserted_in[0]))
        else $error("input state bit written");
    // Writes do store the state bit of an output pin.
    out_write_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && repurpose_enable[FPG_EN_POS1] && setup_q[FPG_DIR_POS1]
        && req.wr && req.addr == FPG_STATE_ADDR
        |=> state_q[FPG_STATE_POS1] == $past(req.wdata[FPG_STATE_POS1]))
        else $error("output state bit not written");
    // The low nibble of the state register keeps what was written.
    test_bits_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && req.wr && req.addr == FPG_STATE_ADDR
        |=> state_q[FPG_TEST_MSB:0] == $past(req.wdata[FPG_TEST_MSB:0]))
        else $error("test bits not stored");
    // A pin that is not repurposed carries the normal fan drive.
    fan_pass_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && !repurpose_enable[FPG_EN_POS1 - 2]
        |=> pin_out[2] == $past(fan_drive_level[2]) && !pin_oe_n[2])
        else $error("fan drive not passed");
    // The filtered level takes stage three once stages two and three agree.
    sync_lag_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && s2_q[0] == s3_q[0] |=> filt_q[0] == $past(s3_q[0]))
        else $error("sampler did not settle");
    // Both registers sit at their reset values while reset is held.
    rst_clear_a: assert property (
        @(posedge ref_clk)
        sys_rst |-> setup_q == FPG_SETUP_RST && state_q == FPG_STATE_RST)
        else $error("registers not cleared");
    // A setup read returns the register on the next edge.
    read_back_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ce && req.rd && req.addr == FPG_SETUP_ADDR
        |=> rd_data == $past(setup_q))
        else $error("setup read wrong");
    // Pin 1 driven high as an enabled output.
    out_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        !pin_oe_n[0] && repurpose_enable[FPG_EN_POS1] && pin_out[0]);
    // Pin 4 input becomes asserted.
    in_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(state_q[FPG_STATE_POS1 + 3]));
    // Software reads the state register.
    rd_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        req.rd && req.addr == FPG_STATE_ADDR);
    // Clock enable low while pin 1 is repurposed.
    freeze_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        !ce && repurpose_enable[FPG_EN_POS1]);
    // Pin 1 asserted as an active-low input.
    low_in_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        !setup_q[FPG_POL_POS1] && !setup_q[FPG_DIR_POS1]
        && state_q[FPG_STATE_POS1]);
endmodule

/* File: fpg_pkg.sv */
/*
 * Shared constants and types for the fan pin general I/O block.
 * Assumes a byte-wide register port decoded from the serial host
 * interface on the same clock as the block.
 */
package fpg_pkg;
    localparam int FPG_PINS = 4;
    localparam logic [7:0] FPG_SETUP_ADDR = 8'h80;
    localparam logic [7:0] FPG_STATE_ADDR = 8'h81;
    localparam logic [7:0] FPG_SETUP_RST = 8'h00;
    localparam logic [7:0] FPG_STATE_RST = 8'h00;
    // Pin n (index i = n-1) fields inside the setup register.
    localparam int FPG_DIR_POS1 = 7;
    localparam int FPG_POL_POS1 = 6;
    localparam int FPG_FIELD_STEP = 2;
    // State bits for pins 1..4 sit from this bit upward.
    localparam int FPG_STATE_POS1 = 4;
    localparam int FPG_TEST_MSB = 3;
    // Repurpose enable bit of pin 1; later pins sit one bit lower each.
    localparam int FPG_EN_POS1 = 3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fpg_req_t;
endpackage

/* File: fpg_board.sv */
/*
 * Board logic on the four repurposed fan-drive pins.
 * Assumes pin_oe_n low means the block drives the pin.
 */
`timescale 1ns/10ps
module fpg_board (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] ext_level,
    output logic [3:0] pin_in
);
    // Each wire shows the block's level when driven, else the board's.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
        end
    end
endmodule

/* File: fan_pin_general_io_tb.sv */
/*
 * Self-checking bench for the fan pin general I/O port.
 * Assumes fpg_port and the board model fpg_board are compiled first.
 */
`timescale 1ns/10ps
module fan_pin_general_io_tb
    import fpg_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b0;
    logic ce = 1'b1;
    fpg_req_t req = '0;
    logic [3:0] en = 4'h0, duty = 4'h0, fan = 4'h0, ext = 4'h0;
    logic [7:0] rd_data;
    logic [3:0] pin_out, pin_oe_n, pin_in;
    int n_fail = 0, checks_done = 0, cyc = 0;

    // Block under test and the board on its pins.
    fpg_port u_fpg_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
        .req(req), .rd_data(rd_data), .repurpose_enable(en),
        .min_duty_lsb(duty), .fan_drive_level(fan), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    fpg_board u_fpg_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_level(ext), .pin_in(pin_in));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // A hang is cut short well past the expected run length.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // One-cycle write strobe; pins have settled when the task returns.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        idle(1);
        req = '0;
        idle(1);
    endtask

    // One-cycle read strobe, then the held read data is compared.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        idle(1);
        req = '0;
        idle(1);
        chk(rd_data, exp);
    endtask

    // Reset rises at a falling edge so the design sees a real reset edge.
    task automatic t_reset;
        @(negedge ref_clk);
        sys_rst = 1'b1;
        idle(12);
        chk({4'h0, pin_oe_n}, 8'h0f);
        sys_rst = 1'b0;
        rdchk(8'h80, 8'h00);
        rdchk(8'h81, 8'h00);
        rdchk(8'h7f, 8'h00);
    endtask

    task automatic t_setup;
        wr(8'h80, 8'ha5);
        rdchk(8'h80, 8'ha5);
        wr(8'h80, 8'h5a);
        rdchk(8'h80, 8'h5a);
    endtask

    // Outputs: state bits 6 and 4 drive pins 3 and 1, duty LSB adds pin 4.
    task automatic t_out;
        en = 4'hf;
        wr(8'h80, 8'hff);
        wr(8'h81, 8'h50);
        chk({pin_oe_n, pin_out}, 8'h05);
        rdchk(8'h81, 8'h50);
        duty = 4'h8;
        idle(2);
        chk({4'h0, pin_out}, 8'h0d);
        wr(8'h80, 8'haa);
        chk({4'h0, pin_out}, 8'h02);
    endtask

    // Inputs pass a synchroniser before the read-only state bits follow.
    task automatic t_in;
        duty = 4'h0;
        ext = 4'he;
        wr(8'h80, 8'h00);
        idle(6);
        chk({4'h0, pin_oe_n}, 8'h0f);
        rdchk(8'h81, 8'h10);
        wr(8'h81, 8'hf0);
        rdchk(8'h81, 8'h10);
        ext = 4'hf;
        rdchk(8'h81, 8'h10);
        idle(6);
        rdchk(8'h81, 8'h00);
        wr(8'h80, 8'h55);
        ext = 4'he;
        idle(6);
        rdchk(8'h81, 8'he0);
    endtask

    // Pins not repurposed carry the fan drive; ce low freezes the pins.
    task automatic t_dis;
        en = 4'h0;
        fan = 4'h9;
        idle(2);
        chk({pin_oe_n, pin_out}, 8'h09);
        ce = 1'b0;
        en = 4'h8;
        fan = 4'h6;
        idle(2);
        chk({pin_oe_n, pin_out}, 8'h09);
        ce = 1'b1;
        idle(2);
        chk({4'h0, pin_oe_n}, 8'h01);
    endtask

    initial begin
        t_reset();
        t_setup();
        t_out();
        t_in();
        t_dis();
        give_verdict();
    end
endmodule
